/* src/cmp_digital_pkg.sv */
// Register map and field layout of the comparator digital back end
package cmp_digital_pkg;
	localparam logic [7:0] ADDR_READ_CLEAR = 8'h78;
	localparam logic [7:0] ADDR_INPUT_SELECT = 8'h79;
	localparam logic [7:0] ADDR_ENABLE_CONTROL = 8'h7a;
	localparam logic [7:0] ADDR_OUTPUT_OPTIONS = 8'h7b;
	localparam logic [7:0] ADDR_LOGIC_FUNCTION = 8'h7c;
	// Printed offsets are not word multiples: byte address is four times the index
	localparam int ADDR_SHIFT = 2;
	localparam logic [7:0] RESET_INPUT_SELECT = 8'h00;
	localparam logic [7:0] RESET_ENABLE_CONTROL = 8'h00;
	localparam logic [7:0] RESET_OUTPUT_OPTIONS = 8'h00;
	localparam logic [7:0] RESET_LOGIC_FUNCTION = 8'h00;
	// Field positions, comparator 0 base; comparator 1 sits BIT_C1_OFS above, except status bits, where it sits one above
	localparam int BIT_C1_OFS = 4;
	localparam int BIT_LATCHED_C0 = 0;
	localparam int BIT_LATCHED_C1 = 1;
	localparam int BIT_LIVE_C0 = 4;
	localparam int BIT_MAIN_SEL = 0;
	localparam int BIT_CLEAR_SEL = 1;
	localparam int BIT_PIN_SEL = 2;
	localparam int BIT_ANALOG_CONN = 3;
	localparam int BIT_ENABLE = 0;
	localparam int FUNC_WIDTH = 4;
	localparam logic [7:0] ENABLE_MASK = 8'h11;
endpackage

/* src/dual_comparator_lut_latch.sv */
// Comparator pair digital back end: lookup, latch, routing and AHB-Lite registers
// Functional notes
// - Each comparator's lookup combines own output A and neighbour output B, 16 functions.
// - Codes 0,F,3,5,1,7,8,6,9,E give low, high, A, B, AND, OR, NOR, XOR, XNOR, NAND.
// - Comparator 1 function in bits 7:4, comparator 0 in bits 3:0.
// - Lookup output sets that comparator's latch.
// - Latch cleared by writing zero to its status bit, or other lookup rising edge.
// - Clear select is output-options bit 5 for comparator 1, bit 1 for 0.
// - Status bits 5 and 4 return live lookup output of comparators 1 and 0.
// - Status bits 1 and 0 stay high once lookup went high, until cleared.
// - Bits 4 and 0 pick lookup or latch for sensing and interrupt outputs.
// - Bits 6 and 2 pick lookup or latch for the pin output.
// - Bits 7 and 3 connect comparator output onto analog output.
// - Enable register bit 0 enables comparator 0, bit 4 comparator 1.
// - Input select holds four 2-bit fields: pos1, neg1, pos0, neg0.
`timescale 1ns/1ps
module dual_comparator_lut_latch
	import cmp_digital_pkg::*;
#(
	parameter int ADDR_WIDTH = 12
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [ADDR_WIDTH-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [1:0] comp_raw,
	output logic [1:0] enable,
	output logic [1:0] pos_input_sel_c0,
	output logic [1:0] neg_input_sel_c0,
	output logic [1:0] pos_input_sel_c1,
	output logic [1:0] neg_input_sel_c1,
	output logic [1:0] main_out,
	output logic [1:0] pin_out,
	output logic [1:0] analog_out_connect
);

	initial
	begin
		if (ADDR_WIDTH < 9 || ADDR_WIDTH > 32)
			$error("ADDR_WIDTH must lie between 9 and 32");
	end

	logic [7:0] input_select_r, input_select_nxt;
	logic [7:0] enable_control_r, enable_control_nxt;
	logic [7:0] output_options_r, output_options_nxt;
	logic [7:0] logic_function_r, logic_function_nxt;
	logic [1:0] latched_r, latched_nxt;
	logic [1:0] lut_prev_r, lut_prev_nxt;
	logic wr_pend_r, wr_pend_nxt;
	logic rd_pend_r, rd_pend_nxt;
	logic [7:0] idx_r, idx_nxt;
	logic [31:0] hrdata_r, hrdata_nxt;
	logic [1:0] lut_out;
	logic [1:0] lut_rise;
	logic [1:0] wr_clear;
	logic [7:0] status_view;
	logic take;

	function automatic logic lut_eval(input logic [3:0] code, input logic a, input logic b);
		// Bit index {!a,!b} gives every code its truth-table meaning in one lookup
		lut_eval = code[{~a, ~b}];
	endfunction

	always_comb
	begin
		lut_out[0] = lut_eval(logic_function_r[FUNC_WIDTH-1:0], comp_raw[0], comp_raw[1]);
		lut_out[1] = lut_eval(logic_function_r[2*FUNC_WIDTH-1:FUNC_WIDTH], comp_raw[1], comp_raw[0]);
		lut_rise = lut_out & ~lut_prev_r;
		status_view = 8'h00;
		status_view[BIT_LIVE_C0] = lut_out[0];
		status_view[BIT_LIVE_C0+1] = lut_out[1];
		status_view[BIT_LATCHED_C0] = latched_r[0];
		status_view[BIT_LATCHED_C1] = latched_r[1];
	end

	assign take = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	// Read data only stands in a read data phase; a write data phase shows zero
	assign hrdata = rd_pend_r ? hrdata_r : 32'h0000_0000;

	always_comb
	begin
		wr_pend_nxt = take && hwrite;
		rd_pend_nxt = take && !hwrite;
		idx_nxt = take ? 8'(haddr >> ADDR_SHIFT) : idx_r;
		hrdata_nxt = 32'h0000_0000;
		if (take && !hwrite)
		begin
			unique case (8'(haddr >> ADDR_SHIFT))
				ADDR_READ_CLEAR: hrdata_nxt = {24'h000000, status_view};
				ADDR_INPUT_SELECT: hrdata_nxt = {24'h000000, input_select_r};
				ADDR_ENABLE_CONTROL: hrdata_nxt = {24'h000000, enable_control_r};
				ADDR_OUTPUT_OPTIONS: hrdata_nxt = {24'h000000, output_options_r};
				ADDR_LOGIC_FUNCTION: hrdata_nxt = {24'h000000, logic_function_r};
				default: hrdata_nxt = 32'h0000_0000;
			endcase
		end
		input_select_nxt = input_select_r;
		enable_control_nxt = enable_control_r;
		output_options_nxt = output_options_r;
		logic_function_nxt = logic_function_r;
		wr_clear = 2'b00;
		// Reserved bits are not stored, so they read zero whatever software writes
		if (wr_pend_r)
		begin
			unique case (idx_r)
				ADDR_INPUT_SELECT: input_select_nxt = hwdata[7:0];
				ADDR_ENABLE_CONTROL: enable_control_nxt = hwdata[7:0] & ENABLE_MASK;
				ADDR_OUTPUT_OPTIONS: output_options_nxt = hwdata[7:0];
				ADDR_LOGIC_FUNCTION: logic_function_nxt = hwdata[7:0];
				ADDR_READ_CLEAR: wr_clear = ~{hwdata[BIT_LATCHED_C1], hwdata[BIT_LATCHED_C0]};
				default: wr_clear = 2'b00;
			endcase
		end
		lut_prev_nxt = lut_out;
		for (int i = 0; i < 2; i++)
		begin
			// Clear is taken first so a set in the same cycle wins
			if (output_options_r[i*BIT_C1_OFS+BIT_CLEAR_SEL])
				latched_nxt[i] = latched_r[i] && !lut_rise[1-i];
			else
				latched_nxt[i] = latched_r[i] && !wr_clear[i];
			if (lut_out[i])
				latched_nxt[i] = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			input_select_r <= RESET_INPUT_SELECT;
			enable_control_r <= RESET_ENABLE_CONTROL;
			output_options_r <= RESET_OUTPUT_OPTIONS;
			logic_function_r <= RESET_LOGIC_FUNCTION;
			latched_r <= 2'b00;
			lut_prev_r <= 2'b00;
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			idx_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end
		else
		begin
			input_select_r <= input_select_nxt;
			enable_control_r <= enable_control_nxt;
			output_options_r <= output_options_nxt;
			logic_function_r <= logic_function_nxt;
			latched_r <= latched_nxt;
			lut_prev_r <= lut_prev_nxt;
			wr_pend_r <= wr_pend_nxt;
			rd_pend_r <= rd_pend_nxt;
			idx_r <= idx_nxt;
			hrdata_r <= hrdata_nxt;
		end
	end

	always_comb
	begin
		enable[0] = enable_control_r[BIT_ENABLE];
		enable[1] = enable_control_r[BIT_ENABLE+BIT_C1_OFS];
		neg_input_sel_c0 = input_select_r[1:0];
		pos_input_sel_c0 = input_select_r[3:2];
		neg_input_sel_c1 = input_select_r[5:4];
		pos_input_sel_c1 = input_select_r[7:6];
		for (int i = 0; i < 2; i++)
		begin
			main_out[i] = output_options_r[i*BIT_C1_OFS+BIT_MAIN_SEL] ? latched_r[i] : lut_out[i];
			pin_out[i] = output_options_r[i*BIT_C1_OFS+BIT_PIN_SEL] ? latched_r[i] : lut_out[i];
			analog_out_connect[i] = output_options_r[i*BIT_C1_OFS+BIT_ANALOG_CONN];
		end
	end

	a_lut_sets_latch: assert property (@(posedge hclk) disable iff (!hresetn) lut_out[0] |=> latched_r[0])
		else $error("latch 0 not set after lookup high");
	a_lut_sets_latch1: assert property (@(posedge hclk) disable iff (!hresetn) lut_out[1] |=> latched_r[1])
		else $error("latch 1 not set after lookup high");
	a_latch_holds: assert property (@(posedge hclk) disable iff (!hresetn)
		latched_r[0] && !wr_pend_r && !lut_rise[1] |=> latched_r[0])
		else $error("latch 0 dropped without a clear");
	a_edge_clear_c0: assert property (@(posedge hclk) disable iff (!hresetn)
		output_options_r[BIT_CLEAR_SEL] && lut_rise[1] && !lut_out[0] |=> !latched_r[0])
		else $error("latch 0 not cleared by neighbour edge");
	a_write_clear_c1: assert property (@(posedge hclk) disable iff (!hresetn)
		!output_options_r[BIT_C1_OFS+BIT_CLEAR_SEL] && wr_pend_r && idx_r == ADDR_READ_CLEAR
		&& !hwdata[BIT_LATCHED_C1] && !lut_out[1] |=> !latched_r[1])
		else $error("latch 1 not cleared by write");
	a_main_select: assert property (@(posedge hclk) disable iff (!hresetn)
		main_out[1] == (output_options_r[4] ? latched_r[1] : lut_out[1]))
		else $error("main output 1 mis-routed");
	a_pin_select: assert property (@(posedge hclk) disable iff (!hresetn)
		pin_out[0] == (output_options_r[2] ? latched_r[0] : lut_out[0]))
		else $error("pin output 0 mis-routed");
	a_lut_xor: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[3:0] == 4'h6 |-> lut_out[0] == (comp_raw[0] ^ comp_raw[1]))
		else $error("xor code wrong");
	a_lut_notb: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[7:4] == 4'ha |-> lut_out[1] == !comp_raw[0])
		else $error("not-b code wrong");
	a_read_live: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && haddr == ADDR_WIDTH'({ADDR_READ_CLEAR, 2'b00}) |=> hrdata[5] == $past(lut_out[1]))
		else $error("live bit wrong");
	a_enable_map: assert property (@(posedge hclk) disable iff (!hresetn)
		enable == {enable_control_r[4], enable_control_r[0]})
		else $error("enable map wrong");

	// Edge clear of comparator 1, write clear of comparator 0 and the inactive clear path of each latch
	a_edge_clear_c1: assert property (@(posedge hclk) disable iff (!hresetn)
		output_options_r[BIT_C1_OFS+BIT_CLEAR_SEL] && lut_rise[0] && !lut_out[1] |=> !latched_r[1])
		else $error("latch 1 not cleared by neighbour edge");
	a_write_clear_c0: assert property (@(posedge hclk) disable iff (!hresetn)
		!output_options_r[BIT_CLEAR_SEL] && wr_pend_r && idx_r == ADDR_READ_CLEAR
		&& !hwdata[BIT_LATCHED_C0] && !lut_out[0] |=> !latched_r[0])
		else $error("latch 0 not cleared by write");
	a_write_ignored_c0: assert property (@(posedge hclk) disable iff (!hresetn)
		output_options_r[BIT_CLEAR_SEL] && latched_r[0] && !lut_rise[1] |=> latched_r[0])
		else $error("latch 0 cleared while edge clearing selected");
	a_write_ignored_c1: assert property (@(posedge hclk) disable iff (!hresetn)
		output_options_r[BIT_C1_OFS+BIT_CLEAR_SEL] && latched_r[1] && !lut_rise[0] |=> latched_r[1])
		else $error("latch 1 cleared while edge clearing selected");
	a_latch_holds_c1: assert property (@(posedge hclk) disable iff (!hresetn)
		latched_r[1] && !wr_pend_r && !lut_rise[0] |=> latched_r[1])
		else $error("latch 1 dropped without a clear");
	a_rise_detect: assert property (@(posedge hclk) disable iff (!hresetn)
		lut_rise == (lut_out & ~$past(lut_out)))
		else $error("lookup rising edge misdetected");

	// Routing and register fields
	a_main_select_c0: assert property (@(posedge hclk) disable iff (!hresetn)
		main_out[0] == (output_options_r[0] ? latched_r[0] : lut_out[0]))
		else $error("main output 0 mis-routed");
	a_pin_select_c1: assert property (@(posedge hclk) disable iff (!hresetn)
		pin_out[1] == (output_options_r[6] ? latched_r[1] : lut_out[1]))
		else $error("pin output 1 mis-routed");
	a_analog_conn_map: assert property (@(posedge hclk) disable iff (!hresetn)
		analog_out_connect == {output_options_r[7], output_options_r[3]})
		else $error("analog connect map wrong");
	a_input_sel_map: assert property (@(posedge hclk) disable iff (!hresetn)
		{pos_input_sel_c1, neg_input_sel_c1, pos_input_sel_c0, neg_input_sel_c0} == input_select_r)
		else $error("input select map wrong");
	a_enable_stored: assert property (@(posedge hclk) disable iff (!hresetn)
		(enable_control_r & ~ENABLE_MASK) == 8'h00)
		else $error("enable register holds unused bits");
	a_function_lands: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_r && idx_r == ADDR_LOGIC_FUNCTION |=> logic_function_r == $past(hwdata[7:0]))
		else $error("function register write lost");
	a_read_latched: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && haddr == ADDR_WIDTH'({ADDR_READ_CLEAR, 2'b00}) |=> hrdata[1:0] == $past(latched_r))
		else $error("latched bits read wrong");
	a_read_upper_zero: assert property (@(posedge hclk) disable iff (!hresetn)
		hrdata[31:8] == 24'h000000)
		else $error("upper read data not zero");

	// Function codes, comparator 0 sees A = own, B = neighbour
	a_lut_low: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[3:0] == 4'h0 |-> !lut_out[0])
		else $error("low code wrong");
	a_lut_and: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[3:0] == 4'h1 |-> lut_out[0] == (comp_raw[0] && comp_raw[1]))
		else $error("and code wrong");
	a_lut_a_notb: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[3:0] == 4'h2 |-> lut_out[0] == (comp_raw[0] && !comp_raw[1]))
		else $error("a and not b code wrong");
	a_lut_own: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[3:0] == 4'h3 |-> lut_out[0] == comp_raw[0])
		else $error("own input code wrong");
	a_lut_nota_b: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[3:0] == 4'h4 |-> lut_out[0] == (!comp_raw[0] && comp_raw[1]))
		else $error("not a and b code wrong");
	a_lut_other: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[3:0] == 4'h5 |-> lut_out[0] == comp_raw[1])
		else $error("neighbour input code wrong");
	a_lut_or: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[3:0] == 4'h7 |-> lut_out[0] == (comp_raw[0] || comp_raw[1]))
		else $error("or code wrong");
	a_lut_xnor: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[3:0] == 4'h9 |-> lut_out[0] == (comp_raw[0] == comp_raw[1]))
		else $error("xnor code wrong");

	// Function codes, comparator 1 sees A = own, B = neighbour
	a_lut_nor: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[7:4] == 4'h8 |-> lut_out[1] == !(comp_raw[1] || comp_raw[0]))
		else $error("nor code wrong");
	a_lut_a_or_notb: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[7:4] == 4'hb |-> lut_out[1] == (comp_raw[1] || !comp_raw[0]))
		else $error("a or not b code wrong");
	a_lut_nota: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[7:4] == 4'hc |-> lut_out[1] == !comp_raw[1])
		else $error("not a code wrong");
	a_lut_nota_or_b: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[7:4] == 4'hd |-> lut_out[1] == (!comp_raw[1] || comp_raw[0]))
		else $error("not a or b code wrong");
	a_lut_nand: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[7:4] == 4'he |-> lut_out[1] == !(comp_raw[1] && comp_raw[0]))
		else $error("nand code wrong");
	a_lut_high: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[7:4] == 4'hf |-> lut_out[1])
		else $error("high code wrong");
	a_lut_own_c1: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[7:4] == 4'h3 |-> lut_out[1] == comp_raw[1])
		else $error("own input code wrong on comparator 1");
	a_lut_xor_c1: assert property (@(posedge hclk) disable iff (!hresetn)
		logic_function_r[7:4] == 4'h6 |-> lut_out[1] == (comp_raw[1] ^ comp_raw[0]))
		else $error("xor code wrong on comparator 1");

endmodule // dual_comparator_lut_latch

/* tb/comp_pair_model.sv */
// Behavioural pair of analog comparators feeding the back end
`timescale 1ns/1ps
module comp_pair_model
(
	input wire logic hclk,
	input wire logic [1:0] level,
	output logic [1:0] comp_raw
);
	// Outputs settle one clock after the analog inputs move
	initial comp_raw = 2'b00;
	always @(posedge hclk)
		comp_raw <= level;
endmodule // comp_pair_model

/* tb/dual_comparator_lut_latch_tb.sv */
// Self-checking bench for the comparator back end
`timescale 1ns/1ps
module dual_comparator_lut_latch_tb;
	import cmp_digital_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [11:0] haddr = '0;
	logic [1:0] htrans = '0, level = '0, m_lat = '0, m_lut = '0;
	logic [31:0] hwdata = '0, hrdata, x = 75;
	logic [7:0] q, m_opt = '0, m_fn = '0;
	logic hreadyout, hresp;
	logic [1:0] comp_raw, enable, ps0, ns0, ps1, ns1, main_out, pin_out, aoc;
	int n_mismatch = 0, check_count = 0;
	always #20 hclk = ~hclk;
	comp_pair_model i_comp_pair_model (.hclk(hclk), .level(level), .comp_raw(comp_raw));
	dual_comparator_lut_latch i_dual_comparator_lut_latch (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .comp_raw(comp_raw), .enable(enable),
		.pos_input_sel_c0(ps0), .neg_input_sel_c0(ns0), .pos_input_sel_c1(ps1), .neg_input_sel_c1(ns1),
		.main_out(main_out), .pin_out(pin_out), .analog_out_connect(aoc));
	function automatic logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic tick();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
		begin
			@(posedge hclk);
			n++;
			if (n > 50)
			begin
				n_mismatch++;
				end_sim();
			end
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] r);
		hsel <= 1'b1;
		haddr <= {2'b00, a, 2'b00};
		hwrite <= w;
		htrans <= 2'b10;
		tick();
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= {24'h0, d};
		tick();
		r = hrdata[7:0];
		chk("resp", {6'h00, |hrdata[31:8], hresp}, 8'h00);
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, d, q);
		if (a == ADDR_OUTPUT_OPTIONS) m_opt = d;
		if (a == ADDR_LOGIC_FUNCTION) m_fn = d;
	endtask
	task automatic outs();
		logic [1:0] s;
		@(posedge hclk);
		s = {m_opt[4], m_opt[0]};
		chk("main", 8'(main_out), 8'((m_lat & s) | (m_lut & ~s)));
		s = {m_opt[6], m_opt[2]};
		chk("pin", 8'(pin_out), 8'((m_lat & s) | (m_lut & ~s)));
		chk("aconn", 8'(aoc), 8'({m_opt[7], m_opt[3]}));
		bus(ADDR_READ_CLEAR, 1'b0, 8'h00, q);
		chk("status", q, {2'b00, m_lut, 2'b00, m_lat});
	endtask
	task automatic step(input logic [1:0] lv);
		logic [1:0] nl, clr;
		level <= lv;
		repeat (3) @(posedge hclk);
		nl[0] = m_fn[{!lv[0], !lv[1]}];
		nl[1] = m_fn[{1'b1, !lv[1], !lv[0]}];
		clr = {m_opt[5] & nl[0] & !m_lut[0], m_opt[1] & nl[1] & !m_lut[1]};
		m_lat = (m_lat & ~clr) | nl;
		m_lut = nl;
		outs();
	endtask
	task automatic wstat(input logic [7:0] d);
		bus(ADDR_READ_CLEAR, 1'b1, d, q);
		m_lat = m_lat & ~(~{m_opt[5], m_opt[1]} & ~d[1:0]) | m_lut;
		outs();
	endtask
	initial
	begin
		logic [7:0] d;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		for (int a = 8'h78; a < 8'h7e; a++)
		begin
			bus(8'(a), 1'b0, 8'h00, q);
			chk("reset", q, 8'h00);
		end
		repeat (4)
		begin
			d = 8'(rnd());
			wreg(ADDR_INPUT_SELECT, d);
			wreg(ADDR_ENABLE_CONTROL, d & ENABLE_MASK);
			@(posedge hclk);
			chk("insel", {ps1, ns1, ps0, ns0}, d);
			chk("enable", 8'(enable), 8'({d[4], d[0]}));
			bus(ADDR_ENABLE_CONTROL, 1'b0, 8'h00, q);
			chk("enread", q, d & ENABLE_MASK);
		end
		for (int c = 0; c < 16; c++)
		begin
			d = 8'(rnd());
			d[3:0] = 4'(c);
			wreg(ADDR_LOGIC_FUNCTION, d);
			step(level);
			for (int v = 0; v < 4; v++)
				step(2'(v));
			wstat(8'h00);
		end
		// Edge clearing and latched routing, both routing select settings per comparator, both clear select settings for comparator 1
		wreg(ADDR_LOGIC_FUNCTION, 8'h33);
		step(level);
		wreg(ADDR_OUTPUT_OPTIONS, 8'h9b);
		step(2'b00);
		wstat(8'h00);
		step(2'b01);
		step(2'b00);
		wstat(8'h00);
		step(2'b10);
		step(2'b00);
		wstat(8'h03);
		wstat(8'h00);
		wreg(ADDR_OUTPUT_OPTIONS, 8'h66);
		step(2'b01);
		step(2'b00);
		step(2'b10);
		step(2'b01);
		end_sim();
	end
endmodule // dual_comparator_lut_latch_tb
